// >>> design/cross_chip_credit_limiter.sv
//Contract
// - Each chip sits in exactly one group
// - Registers exist only without coherent option, <=16 chips
// - Map holds 2-bit selector per chip index
// - Selector value is the group number directly
// - Local chip index comes from tie-off input
// - Limits register: four 8-bit group limits
// - Nonzero limit caps group's outstanding transactions
// - Zero limit means no cap; code still stalls a group once its count reaches COUNT_MAX
// - Registers accessible only by Secure accesses
`timescale 1ns/10ps
`default_nettype none

module cross_chip_credit_limiter
  import credit_limiter_pkg::*;
#(
  parameter int unsigned N_CHIPS = NUM_CHIPS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // Configuration tie-offs, asynchronous to pclk
  input wire chip_cfg_t cfg_pins,
  // Transaction issue request and grant
  input wire xfer_t issue_req,
  output logic issue_ready,
  // Completion returned by the remote chip
  input wire xfer_t completion,
  // Register availability, for system status
  output logic regs_available
);

  // Two-stage synchroniser for the tie-offs
  chip_cfg_t cfg_meta_q;
  chip_cfg_t cfg_q;

  // Software registers
  logic [DATA_W-1:0] group_map_q;
  logic [DATA_W-1:0] credit_limits_q;

  // Per-group outstanding counters
  logic [LIMIT_W-1:0] outstanding_q [NUM_GROUPS];

  // Registered read data and error
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;

  // Decoded views
  logic avail;
  logic [DATA_W-1:0] map_eff;
  logic [DATA_W-1:0] lim_eff;
  credit_group_t req_grp;
  credit_group_t cpl_grp;
  logic req_remote;
  logic cpl_remote;
  logic issue_fire;
  logic setup_phase;
  logic access_phase;
  logic acc_secure;
  logic [DATA_W-1:0] outstanding_word;
  logic [NUM_GROUPS-1:0] grp_open;

  // Group of a chip as chosen by the map
  function automatic credit_group_t group_of(input logic [DATA_W-1:0] map, input logic [CHIP_W-1:0] chip);
    group_of = credit_group_t'(map[GROUP_W*chip +: GROUP_W]);
  endfunction

  // Limit field of one group
  function automatic logic [LIMIT_W-1:0] limit_of(input logic [DATA_W-1:0] lims, input int unsigned grp);
    limit_of = lims[LIMIT_W*grp +: LIMIT_W];
  endfunction

  // Synchronise the tie-offs before any logic reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_meta_q <= '0;
      cfg_q <= '0;
    end
    else
    begin
      cfg_meta_q <= cfg_pins;
      cfg_q <= cfg_meta_q;
    end
  end

  // Registers exist only in the small non-coherent setup
  assign avail = !cfg_q.coherent_cross_chip_option && (cfg_q.chips_upper == CHIPS_UPPER_NONE);
  assign regs_available = avail;

  // Absent registers behave as all zero, so no limit applies
  assign map_eff = avail ? group_map_q : DATA_ZERO;
  assign lim_eff = avail ? credit_limits_q : DATA_ZERO;

  // Bus phases and security
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign acc_secure = !pprot[PROT_NS_BIT];

  // Writes land in the access phase, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group_map_q <= GROUP_MAP_RESET;
      credit_limits_q <= CREDIT_LIMITS_RESET;
    end
    else if (access_phase && pwrite && acc_secure && avail)
    begin
      // Byte strobes honoured on both writable words
      for (int b = 0; b < DATA_W/8; b++)
      begin
        if (pstrb[b] && paddr == OFF_GROUP_MAP)
        begin
          group_map_q[8*b +: 8] <= pwdata[8*b +: 8];
        end
        if (pstrb[b] && paddr == OFF_CREDIT_LIMITS)
        begin
          credit_limits_q[8*b +: 8] <= pwdata[8*b +: 8];
        end
      end
    end
  end

  // Outstanding counts packed into one status word
  always_comb
  begin
    outstanding_word = DATA_ZERO;
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      outstanding_word[LIMIT_W*g +: LIMIT_W] = outstanding_q[g];
    end
  end

  // Read data and error prepared in the setup cycle, so they come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= DATA_ZERO;
      pslverr_q <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_q <= DATA_ZERO;
      pslverr_q <= 1'b0;
      if (!acc_secure)
      begin
        // Non-secure sees nothing and gets an error
        pslverr_q <= 1'b1;
      end
      else if (paddr == OFF_GROUP_MAP)
      begin
        prdata_q <= pwrite ? DATA_ZERO : map_eff;
      end
      else if (paddr == OFF_CREDIT_LIMITS)
      begin
        prdata_q <= pwrite ? DATA_ZERO : lim_eff;
      end
      else if (paddr == OFF_OUTSTANDING)
      begin
        // Status word is read-only; writes are dropped silently
        prdata_q <= pwrite ? DATA_ZERO : outstanding_word;
      end
      else
      begin
        // Unmapped address
        pslverr_q <= 1'b1;
      end
    end
  end

  // Answer in the first access cycle
  assign pready = access_phase;
  assign prdata = prdata_q;
  assign pslverr = access_phase && pslverr_q;

  // Group lookup for both directions of traffic
  assign req_grp = group_of(map_eff, issue_req.chip);
  assign cpl_grp = group_of(map_eff, completion.chip);

  // Own chip is never a remote target, so it takes no credit
  assign req_remote = issue_req.chip != cfg_q.chip_index_tieoff;
  assign cpl_remote = completion.chip != cfg_q.chip_index_tieoff;

  // Gate per group; counter saturation also stalls so counts stay honest
  generate
    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : g_grp
      logic [LIMIT_W-1:0] lim;
      logic inc;
      logic dec;
      assign lim = limit_of(lim_eff, g);
      assign grp_open[g] = (lim == LIMIT_NONE) ? (outstanding_q[g] != COUNT_MAX)
                                               : (outstanding_q[g] < lim);
      assign inc = issue_fire && req_remote && (req_grp == credit_group_t'(g));
      assign dec = completion.valid && cpl_remote && (cpl_grp == credit_group_t'(g))
                   && (outstanding_q[g] != LIMIT_NONE);

      // Count from issue to completion
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          outstanding_q[g] <= LIMIT_NONE;
        end
        else if (inc && !dec)
        begin
          outstanding_q[g] <= outstanding_q[g] + 8'h01;
        end
        else if (dec && !inc)
        begin
          outstanding_q[g] <= outstanding_q[g] - 8'h01;
        end
      end
    end
  endgenerate

  // Local traffic always passes; remote waits for its group's credit
  assign issue_ready = !req_remote || grp_open[req_grp];
  assign issue_fire = issue_req.valid && issue_ready;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hold_at_limit: assert property (
    (issue_req.valid && req_remote && limit_of(lim_eff, req_grp) != LIMIT_NONE
     && outstanding_q[req_grp] == limit_of(lim_eff, req_grp)) |-> !issue_ready)
    else $error("Issue granted with group at its limit");

  a_unlimited_pass: assert property (
    (req_remote && limit_of(lim_eff, req_grp) == LIMIT_NONE && outstanding_q[req_grp] != COUNT_MAX)
    |-> issue_ready)
    else $error("Unlimited group stalled");

  a_count_issue: assert property (
    (issue_fire && req_remote && !completion.valid)
    |=> outstanding_q[$past(req_grp)] == $past(outstanding_q[req_grp]) + 8'h01)
    else $error("Outstanding count missed an issue");

  a_count_complete: assert property (
    (completion.valid && cpl_remote && !issue_req.valid && outstanding_q[cpl_grp] != LIMIT_NONE)
    |=> outstanding_q[$past(cpl_grp)] == $past(outstanding_q[cpl_grp]) - 8'h01)
    else $error("Outstanding count missed a completion");

  a_group_decode: assert property (
    avail |-> req_grp == credit_group_t'(group_map_q[GROUP_W*issue_req.chip +: GROUP_W]))
    else $error("Chip mapped to wrong group");

  a_map_read: assert property (
    (setup_phase && !pwrite && acc_secure && avail && paddr == OFF_GROUP_MAP)
    |=> prdata == $past(group_map_q))
    else $error("Group map read mismatch");

  a_limit_write: assert property (
    (access_phase && pwrite && acc_secure && avail && paddr == OFF_CREDIT_LIMITS && pstrb[3])
    |=> credit_limits_q[31:24] == $past(pwdata[31:24]))
    else $error("Group three limit not written");

  a_nonsecure_refused: assert property (
    (setup_phase && !acc_secure) |=> (pslverr && prdata == DATA_ZERO) ##0 $stable(group_map_q)
    ##1 $stable(group_map_q) && $stable(credit_limits_q))
    else $error("Non-secure access not refused");

  a_absent_zero: assert property (
    (setup_phase && !pwrite && acc_secure && !avail && paddr == OFF_CREDIT_LIMITS)
    |=> prdata == DATA_ZERO)
    else $error("Absent register read nonzero");

  a_local_bypass: assert property (
    (issue_req.valid && !req_remote) |-> issue_ready)
    else $error("Local chip traffic stalled");

  // Low selector byte must land as written; a lost strobe would misplace chips
  a_map_write: assert property (
    (access_phase && pwrite && acc_secure && avail && paddr == OFF_GROUP_MAP && pstrb[0])
    |=> group_map_q[7:0] == $past(pwdata[7:0]))
    else $error("Group map byte not written");

  // Absent registers keep their contents through any write
  a_absent_ignored: assert property (
    (access_phase && pwrite && !avail) |=> $stable(group_map_q) && $stable(credit_limits_q))
    else $error("Absent register took a write");

  c_stall_limit: cover property (issue_req.valid && req_remote && !issue_ready);
  c_nonsecure: cover property (access_phase && pslverr && !acc_secure);
  c_limit_reached: cover property (issue_fire ##1 !grp_open[req_grp] ##[1:20] grp_open[req_grp]);
  c_absent_write: cover property (access_phase && pwrite && !avail);

endmodule

`default_nettype wire

// >>> design/credit_limiter_pkg.sv
package credit_limiter_pkg;

  // Bus and register geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_GROUP_MAP = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CREDIT_LIMITS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_OUTSTANDING = 12'h008;

  // Chips, groups and field widths
  localparam int unsigned NUM_CHIPS = 16;
  localparam int unsigned CHIP_W = 4;
  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned GROUP_W = 2;
  localparam int unsigned LIMIT_W = 8;
  localparam int unsigned CHIPS_UPPER_W = 4;

  // Reset values and special field values
  localparam logic [DATA_W-1:0] GROUP_MAP_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CREDIT_LIMITS_RESET = 32'h0000_0000;
  localparam logic [LIMIT_W-1:0] LIMIT_NONE = 8'h00;
  localparam logic [LIMIT_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [CHIPS_UPPER_W-1:0] CHIPS_UPPER_NONE = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Protection bit that marks a Non-secure access
  localparam int unsigned PROT_NS_BIT = 1;

  // Selector encodings for the four credit groups
  typedef enum logic [GROUP_W-1:0]
  {
    GRP_ZERO = 2'b00,
    GRP_ONE = 2'b01,
    GRP_TWO = 2'b10,
    GRP_THREE = 2'b11
  } credit_group_t;

  // Configuration tie-offs of the local chip
  typedef struct packed
  {
    logic coherent_cross_chip_option;
    logic [CHIPS_UPPER_W-1:0] chips_upper;
    logic [CHIP_W-1:0] chip_index_tieoff;
  } chip_cfg_t;

  // One stream transaction request or completion
  typedef struct packed
  {
    logic valid;
    logic [CHIP_W-1:0] chip;
  } xfer_t;

endpackage

// >>> verification/remote_chips_model.sv
`timescale 1ns/10ps
`default_nettype none
module remote_chips_model
  import credit_limiter_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Traffic seen at the limiter
  input wire xfer_t issue_req,
  input wire logic issue_ready,
  input wire logic [CHIP_W-1:0] local_chip,
  // High stalls every answer
  input wire logic hold,
  // Answers back to the limiter
  output var xfer_t completion,
  output logic empty
);
  logic [CHIP_W-1:0] pend_q[$]; // Chips owed an answer, oldest first

  // One answer per cycle at most; idle chip field toggles so stale ids never look valid
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pend_q.delete();
      completion <= '0;
      empty <= 1'b1;
    end
    else
    begin
      if (issue_req.valid && issue_ready && issue_req.chip != local_chip)
        pend_q.push_back(issue_req.chip);
      if (!hold && pend_q.size() != 0)
        completion <= xfer_t'({1'b1, pend_q.pop_front()});
      else
        completion <= xfer_t'({1'b0, ~completion.chip});
      empty <= (pend_q.size() == 0);
    end
endmodule
`default_nettype wire

// >>> verification/cross_chip_credit_limiter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cross_chip_credit_limiter_tb;
  import credit_limiter_pkg::*;
  // Bench drive
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, rnd, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] pprot = 3'h0;
  logic pready, pslverr, issue_ready, regs_available, empty;
  chip_cfg_t cfg_pins = '0;
  xfer_t issue_req = '0, completion;
  logic [32:0] exp_q[$]; // Notes of {error, read data}
  int n_mismatch = 0, total_checks = 0, seed = 43, i;
  always #2.5 pclk = ~pclk;

  cross_chip_credit_limiter dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot,
    .pready, .prdata, .pslverr, .cfg_pins, .issue_req, .issue_ready, .completion, .regs_available);
  remote_chips_model far_u (.pclk, .presetn, .issue_req, .issue_ready, .local_chip(cfg_pins.chip_index_tieoff),
    .hold, .completion, .empty);

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; bounded wait for pready, then one idle cycle
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [2:0] prot, input logic [32:0] exp);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= prot;
    @(posedge pclk);
    penable <= 1'b1;
    exp_q.push_back(exp);
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      n_mismatch++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d, 3'h0, 33'h0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic e);
    apb(1'b0, a, 32'h0, 3'h0, {e, d});
  endtask

  // Request one issue; grant checked mid-cycle, before the edge that takes it
  task automatic iss(input logic [CHIP_W-1:0] c, input logic e);
    issue_req <= xfer_t'({1'b1, c});
    #1;
    chk({32'h0, issue_ready}, {32'h0, e});
    @(posedge pclk);
  endtask

  // Each completed transfer is matched to the oldest note
  always @(posedge pclk)
    if (psel && penable && pready)
      chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.size() != 0 ? exp_q.pop_front() : 33'bx);

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Reset values, random readback, byte strobes
    rd(OFF_GROUP_MAP, GROUP_MAP_RESET, 1'b0);
    rd(OFF_CREDIT_LIMITS, CREDIT_LIMITS_RESET, 1'b0);
    rnd = $random(seed);
    wr(OFF_GROUP_MAP, rnd);
    rd(OFF_GROUP_MAP, rnd, 1'b0);
    pstrb <= 4'b0101;
    wr(OFF_GROUP_MAP, 32'hffff_ffff);
    pstrb <= 4'hf;
    rd(OFF_GROUP_MAP, rnd | 32'h00ff_00ff, 1'b0);
    // Non-secure refused, then unmapped
    apb(1'b1, OFF_CREDIT_LIMITS, 32'h0000_00ff, 3'h2, {1'b1, 32'h0});
    apb(1'b0, OFF_GROUP_MAP, 32'h0, 3'h2, {1'b1, 32'h0});
    rd(OFF_CREDIT_LIMITS, 32'h0, 1'b0);
    rd(12'h00c, 32'h0, 1'b1);
    // Chips 1..4 in groups 0..3, limits 1,2,3 and none
    wr(OFF_GROUP_MAP, 32'h0000_0390);
    wr(OFF_CREDIT_LIMITS, 32'h0003_0201);
    rd(OFF_CREDIT_LIMITS, 32'h0003_0201, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      repeat (i + 1) iss(CHIP_W'(i + 1), 1'b1);
      iss(CHIP_W'(i + 1), i == 3);
    end
    iss(4'h0, 1'b1);
    issue_req <= '0;
    rd(OFF_OUTSTANDING, 32'h0503_0201, 1'b0);
    hold <= 1'b0;
    for (i = 0; i < 60 && empty !== 1'b1; i++)
      @(posedge pclk);
    if (empty !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
    rd(OFF_OUTSTANDING, 32'h0, 1'b0);
    // Coherent option, then more than sixteen chips
    for (i = 0; i < 2; i++)
    begin
      cfg_pins <= i ? chip_cfg_t'({1'b0, 4'h1, 4'h0}) : chip_cfg_t'({1'b1, 4'h0, 4'h0});
      repeat (3) @(posedge pclk);
      chk({32'h0, regs_available}, 33'h0);
      wr(OFF_CREDIT_LIMITS, 32'hffff_ffff);
      rd(OFF_CREDIT_LIMITS, 32'h0, 1'b0);
    end
    // Local index now 1: chip 1 bypasses, chip 0 is limited
    cfg_pins <= chip_cfg_t'({1'b0, 4'h0, 4'h1});
    hold <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(OFF_CREDIT_LIMITS, 32'h0003_0201, 1'b0);
    repeat (3) iss(4'h1, 1'b1);
    iss(4'h0, 1'b1);
    iss(4'h0, 1'b0);
    issue_req <= '0;
    conclude();
  end
endmodule
`default_nettype wire
